// [hdl/tx_channel_ctrl_pkg.sv]
// Package with register map, field layout and timing constants of the per-timeslot controller.
package tx_channel_ctrl_pkg;
   // APB byte addresses; printed offsets are not multiples of four, so byte address = 4 * index.
   localparam logic [7:0]  IDX_CFG        = 8'h30;
   localparam logic [7:0]  IDX_STATUS     = 8'h31;
   localparam logic [7:0]  IDX_POINTER    = 8'h32;
   localparam logic [7:0]  IDX_BUFFER     = 8'h33;
   localparam logic [11:0] ADDR_CFG       = {2'h0, IDX_CFG, 2'h0};
   localparam logic [11:0] ADDR_STATUS    = {2'h0, IDX_STATUS, 2'h0};
   localparam logic [11:0] ADDR_POINTER   = {2'h0, IDX_POINTER, 2'h0};
   localparam logic [11:0] ADDR_BUFFER    = {2'h0, IDX_BUFFER, 2'h0};
   // Reset values.
   localparam logic [7:0]  RST_POINTER    = 8'h00;
   localparam logic [7:0]  RST_BUFFER     = 8'h00;
   localparam logic [1:0]  RST_CFG        = 2'h0;
   // Pointer register fields.
   localparam int          POS_OP_READ    = 7;
   // Configuration and status register fields.
   localparam int          POS_SLOT_EN    = 0;
   localparam int          POS_ACCESS_PTR = 1;
   localparam int          POS_BUSY       = 7;
   // Internal address ranges.
   localparam logic [6:0]  CTRL_BASE      = 7'h20;
   localparam logic [6:0]  CTRL_LAST      = 7'h3F;
   localparam logic [6:0]  IDLE_BASE      = 7'h40;
   localparam logic [6:0]  IDLE_LAST      = 7'h5F;
   // Control byte fields.
   localparam int          POS_REPLACE    = 7;
   localparam int          POS_MSEL0      = 6;
   localparam int          POS_MSEL1      = 5;
   localparam int          POS_SIG_ORIGIN = 4;
   // Access time: a read must land within this many ns.
   localparam int          ACCESS_NS      = 480;
   localparam int          CLK_NS         = 100;
   localparam int          ACCESS_CYC     = ACCESS_NS / CLK_NS;
   // Milliwatt patterns, one byte per row, bit 1 (first sent) in the MSB.
   localparam logic [63:0] ALAW_MW        = 64'h34_21_21_34_B4_A1_A1_B4;
   localparam logic [63:0] ULAW_MW        = 64'h1E_0B_0B_1E_9E_8B_8B_9E;
   // Indirect access sequencer states.
   typedef enum logic [1:0]
   {
      ST_IDLE  = 2'b00,
      ST_READ  = 2'b01,
      ST_WRITE = 2'b10,
      ST_DONE  = 2'b11
   } tx_channel_ctrl_state_t;
endpackage

// [hdl/tx_channel_ctrl_mem.sv]
// Per-timeslot byte memory (32 control plus 32 idle bytes) with registered read ports.
`timescale 1ns/1ps
module tx_channel_ctrl_mem
#(
   parameter int AW = 6
)
(
   // Clock.
   input  wire logic          sys_clk,
   // Software port.
   input  wire logic          wr_en,
   input  wire logic [AW-1:0] sw_addr,
   input  wire logic [7:0]    wr_data,
   output logic      [7:0]    sw_rdata,
   // Transmit-side read port for control and idle bytes of one slot.
   input  wire logic [AW-2:0] slot,
   output logic      [7:0]    ctrl_rdata,
   output logic      [7:0]    idle_rdata
);
   logic [7:0] mem [0:(1<<AW)-1];

   // Memory has no reset; software is expected to program every slot before enabling.
   always_ff @(posedge sys_clk)
   begin
      if (wr_en)
         mem[sw_addr] <= wr_data;
      sw_rdata   <= mem[sw_addr];
      ctrl_rdata <= mem[{1'b0, slot}];
      idle_rdata <= mem[{1'b1, slot}];
   end
endmodule

// [hdl/tx_channel_ctrl_top.sv]
// Transmit per-timeslot controller: APB registers, indirect access and PCM manipulation.
`timescale 1ns/1ps
module tx_channel_ctrl_top
(
   // Clock and reset.
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // APB slave.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Transmit timeslot stream, one byte per slot, bit 1 in the MSB.
   input  wire logic        slot_valid,
   input  wire logic [4:0]  slot_num,
   input  wire logic [7:0]  backplane_tx_pcm,
   input  wire logic [3:0]  backplane_tx_signaling,
   input  wire logic        cas_mode,
   output logic             tx_valid_ff,
   output logic      [7:0]  tx_pcm_stream,
   output logic      [3:0]  tx_sig_ff
);
   // Registers.
   logic [7:0]               ptr_ff;
   logic [7:0]               buf_ff;
   logic [1:0]               cfg_ff;
   tx_channel_ctrl_pkg::tx_channel_ctrl_state_t    st_ff;
   tx_channel_ctrl_pkg::tx_channel_ctrl_state_t    nxt_st;
   logic [2:0]               mw_phase_ff;
   logic [7:0]               pcm_d1_ff;
   logic [3:0]               sig_d1_ff;
   logic                     val_d1_ff;
   logic [4:0]               slot_d1_ff;
   logic [7:0]               tx_pcm_ff;
   // Memory interface.
   logic [7:0]               sw_rdata;
   logic [7:0]               ctrl_byte;
   logic [7:0]               idle_byte;

   // APB decode.
   wire        apb_acc     = psel & penable;
   wire        apb_wr      = apb_acc & pwrite;
   wire        hit_cfg     = (paddr == tx_channel_ctrl_pkg::ADDR_CFG);
   wire        hit_status  = (paddr == tx_channel_ctrl_pkg::ADDR_STATUS);
   wire        hit_ptr     = (paddr == tx_channel_ctrl_pkg::ADDR_POINTER);
   wire        hit_buf     = (paddr == tx_channel_ctrl_pkg::ADDR_BUFFER);
   wire        hit_any     = hit_cfg | hit_status | hit_ptr | hit_buf;
   wire        busy        = (st_ff != tx_channel_ctrl_pkg::ST_IDLE);
   wire [6:0]  tgt_addr    = ptr_ff[6:0];
   // Valid internal targets are the two banks; other addresses are ignored.
   wire        tgt_valid   = (tgt_addr >= tx_channel_ctrl_pkg::CTRL_BASE) &&
                             (tgt_addr <= tx_channel_ctrl_pkg::IDLE_LAST);
   wire        new_valid   = (pwdata[6:0] >= tx_channel_ctrl_pkg::CTRL_BASE) &&
                             (pwdata[6:0] <= tx_channel_ctrl_pkg::IDLE_LAST);
   wire        launch      = apb_wr & hit_ptr & new_valid & ~busy;
   // Bank bit: 20H-3FH maps to 0..31, 40H-5FH to 32..63.
   wire [5:0]  mem_addr    = {tgt_addr[6], tgt_addr[4:0]};
   wire        mem_wr      = (st_ff == tx_channel_ctrl_pkg::ST_WRITE);
   wire [7:0]  rd_mux      = hit_cfg    ? {6'h00, cfg_ff} :
                             hit_status ? {busy, 7'h00} :
                             hit_ptr    ? ptr_ff : buf_ff;

   tx_channel_ctrl_mem #(.AW(6)) u_mem
   (
      .sys_clk    (sys_clk),
      .wr_en      (mem_wr),
      .sw_addr    (mem_addr),
      .wr_data    (buf_ff),
      .sw_rdata   (sw_rdata),
      .slot       (slot_num),
      .ctrl_rdata (ctrl_byte),
      .idle_rdata (idle_byte)
   );

   // Indirect access sequencer; a read needs one cycle for the registered memory port.
   always_comb
   begin
      nxt_st = st_ff;
      case (st_ff)
         tx_channel_ctrl_pkg::ST_IDLE:
            if (launch)
               nxt_st = pwdata[tx_channel_ctrl_pkg::POS_OP_READ] ? tx_channel_ctrl_pkg::ST_READ
                                                     : tx_channel_ctrl_pkg::ST_WRITE;
         tx_channel_ctrl_pkg::ST_READ:  nxt_st = tx_channel_ctrl_pkg::ST_DONE;
         tx_channel_ctrl_pkg::ST_WRITE: nxt_st = tx_channel_ctrl_pkg::ST_IDLE;
         tx_channel_ctrl_pkg::ST_DONE:  nxt_st = tx_channel_ctrl_pkg::ST_IDLE;
         default:            nxt_st = tx_channel_ctrl_pkg::ST_IDLE;
      endcase
   end

   // Sequencer state.
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         st_ff <= tx_channel_ctrl_pkg::ST_IDLE;
      else
         st_ff <= nxt_st;
   end

   // Software registers; pointer writes while busy are dropped to protect the access in flight.
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ptr_ff <= tx_channel_ctrl_pkg::RST_POINTER;
         buf_ff <= tx_channel_ctrl_pkg::RST_BUFFER;
         cfg_ff <= tx_channel_ctrl_pkg::RST_CFG;
      end
      else
      begin
         if (apb_wr && hit_ptr && !busy)
            ptr_ff <= pwdata[7:0];
         if (st_ff == tx_channel_ctrl_pkg::ST_DONE)
            buf_ff <= sw_rdata;
         else if (apb_wr && hit_buf && !busy)
            buf_ff <= pwdata[7:0];
         if (apb_wr && hit_cfg)
            cfg_ff <= pwdata[1:0];
      end
   end

   // APB answer: zero wait states, unmapped addresses flag an error and read zero.
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~hit_any;
         prdata  <= (psel & ~penable & hit_any) ? {24'h00_0000, rd_mux} : 32'h0000_0000;
      end
   end

   // Pipeline stage aligning the stream with the registered slot bytes.
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         val_d1_ff  <= 1'b0;
         pcm_d1_ff  <= 8'h00;
         sig_d1_ff  <= 4'h0;
         slot_d1_ff <= 5'h00;
      end
      else
      begin
         val_d1_ff  <= slot_valid;
         pcm_d1_ff  <= backplane_tx_pcm;
         sig_d1_ff  <= backplane_tx_signaling;
         slot_d1_ff <= slot_num;
      end
   end

   // Control byte decode.
   wire        replace_enable       = ctrl_byte[tx_channel_ctrl_pkg::POS_REPLACE];
   wire        manip_sel_0          = ctrl_byte[tx_channel_ctrl_pkg::POS_MSEL0];
   wire        manip_sel_1          = ctrl_byte[tx_channel_ctrl_pkg::POS_MSEL1];
   wire        signaling_origin_sel = ctrl_byte[tx_channel_ctrl_pkg::POS_SIG_ORIGIN];
   wire        slots_on             = cfg_ff[tx_channel_ctrl_pkg::POS_SLOT_EN];
   wire [5:0]  mw_shift             = 6'(({3'h0, mw_phase_ff} ^ 6'h07) << 3);
   wire [7:0]  alaw_byte            = 8'(tx_channel_ctrl_pkg::ALAW_MW >> mw_shift);
   wire [7:0]  ulaw_byte            = 8'(tx_channel_ctrl_pkg::ULAW_MW >> mw_shift);
   // Inversion masks; bit 1 sits in the MSB, so odd bits are 8'hAA.
   wire [7:0]  inv_mask             = {manip_sel_0, manip_sel_1} == 2'b01 ? 8'hAA :
                                      {manip_sel_0, manip_sel_1} == 2'b10 ? 8'h55 :
                                      {manip_sel_0, manip_sel_1} == 2'b11 ? 8'hFF :
                                      8'h00;
   // Idle byte sent MSB first, which is the first transmitted position.
   wire [7:0]  manip_pcm            = !replace_enable ? pcm_d1_ff ^ inv_mask :
                                      !manip_sel_0    ? idle_byte :
                                      !manip_sel_1    ? alaw_byte :
                                      ulaw_byte;
   wire [7:0]  out_pcm              = slots_on ? manip_pcm : pcm_d1_ff;
   wire        use_alt_sig          = slots_on & cas_mode & signaling_origin_sel;
   wire [3:0]  out_sig              = use_alt_sig ? ctrl_byte[3:0] : sig_d1_ff;

   // Output stage; milliwatt phase advances once per frame, at slot 31.
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_valid_ff <= 1'b0;
         tx_pcm_ff   <= 8'h00;
         tx_sig_ff   <= 4'h0;
         mw_phase_ff <= 3'h0;
      end
      else
      begin
         tx_valid_ff <= val_d1_ff;
         if (val_d1_ff)
         begin
            tx_pcm_ff <= out_pcm;
            tx_sig_ff <= out_sig;
         end
         if (val_d1_ff && slot_d1_ff == 5'h1F)
            mw_phase_ff <= mw_phase_ff + 3'h1;
      end
   end

   assign tx_pcm_stream = tx_pcm_ff;

   // A read completes in two cycles, well inside the allowed time.
   chk_read_deadline: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (st_ff == tx_channel_ctrl_pkg::ST_READ) |-> ##[1:3] (st_ff == tx_channel_ctrl_pkg::ST_IDLE))
      else $error("Indirect read exceeded access time.");

   chk_launch_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
      launch && pwdata[7] |=> st_ff == tx_channel_ctrl_pkg::ST_READ)
      else $error("Read request did not start a read.");

   chk_launch_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
      launch && !pwdata[7] |=> st_ff == tx_channel_ctrl_pkg::ST_WRITE ##1 !busy)
      else $error("Write request did not complete in one cycle.");

   chk_read_data: assert property (@(posedge sys_clk) disable iff (!rst_n)
      st_ff == tx_channel_ctrl_pkg::ST_DONE |=> buf_ff == $past(sw_rdata))
      else $error("Read data not placed in buffer.");

   chk_pass_thru: assert property (@(posedge sys_clk) disable iff (!rst_n)
      val_d1_ff && (!slots_on || ctrl_byte[7:5] == 3'b000) |=> tx_pcm_ff == $past(pcm_d1_ff))
      else $error("Pass-through data altered.");

   chk_full_invert: assert property (@(posedge sys_clk) disable iff (!rst_n)
      val_d1_ff && slots_on && ctrl_byte[7:5] == 3'b011 |=> tx_pcm_ff == ~$past(pcm_d1_ff))
      else $error("Full inversion wrong.");

   chk_idle_subst: assert property (@(posedge sys_clk) disable iff (!rst_n)
      val_d1_ff && slots_on && ctrl_byte[7:6] == 2'b10 |=> tx_pcm_ff == $past(idle_byte))
      else $error("Idle byte not substituted.");

   chk_sig_source: assert property (@(posedge sys_clk) disable iff (!rst_n)
      val_d1_ff && !cas_mode |=> tx_sig_ff == $past(sig_d1_ff))
      else $error("Signaling origin used without CAS.");
endmodule

// [tb/tx_channel_ctrl_host.sv]
// APB master model standing in for the microprocessor that programs the controller.
`timescale 1ns/1ps
module tx_channel_ctrl_host
(
   // Clock.
   input  wire logic        sys_clk,
   // APB master side.
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic      [11:0] paddr,
   output logic      [31:0] pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   logic [31:0] last_rd = 32'h0;
   logic        last_err = 1'b0;

   // Bus idle at time zero.
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
   end

   // One transfer, held until pready is seen high; a missing answer leaves last_err set.
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      last_err = 1'b1;
      for (int n = 0; n < 16; n++)
      begin
         @(posedge sys_clk);
         if (pready === 1'b1)
         begin
            last_rd = prdata;
            last_err = pslverr;
            break;
         end
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Indirect write: data first, then the pointer, then wait for busy to drop.
   task automatic ind_write(input logic [6:0] a, input logic [7:0] d);
      xfer(1'b1, tx_channel_ctrl_pkg::ADDR_BUFFER, {24'h0, d});
      xfer(1'b1, tx_channel_ctrl_pkg::ADDR_POINTER, {24'h0, 1'b0, a});
      for (int n = 0; n < 16; n++)
      begin
         xfer(1'b0, tx_channel_ctrl_pkg::ADDR_STATUS, 32'h0);
         if (last_rd[tx_channel_ctrl_pkg::POS_BUSY] === 1'b0)
            break;
      end
   endtask

   // Indirect read: pointer only, then the buffer is fetched once the access time is over.
   task automatic ind_read(input logic [6:0] a);
      xfer(1'b1, tx_channel_ctrl_pkg::ADDR_POINTER, {24'h0, 1'b1, a});
      repeat (tx_channel_ctrl_pkg::ACCESS_CYC - 1) @(posedge sys_clk);
      xfer(1'b0, tx_channel_ctrl_pkg::ADDR_BUFFER, 32'h0);
   endtask
endmodule

// [tb/test_tx_channel_ctrl_top.sv]
// Self-checking bench for the transmit per-timeslot controller.
`timescale 1ns/1ps
module test_tx_channel_ctrl_top;
   logic        sys_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic        slot_valid = 1'b0;
   logic [4:0]  slot_num = 5'h00;
   logic [7:0]  backplane_tx_pcm = 8'h00;
   logic [3:0]  backplane_tx_signaling = 4'h0;
   logic        cas_mode = 1'b0;
   logic        tx_valid_ff;
   logic [7:0]  tx_pcm_stream;
   logic [3:0]  tx_sig_ff;
   int          bad_count = 0;
   int          comparisons = 0;

   tx_channel_ctrl_top u_tx_channel_ctrl_top (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .slot_valid(slot_valid), .slot_num(slot_num),
      .backplane_tx_pcm(backplane_tx_pcm), .backplane_tx_signaling(backplane_tx_signaling),
      .cas_mode(cas_mode), .tx_valid_ff(tx_valid_ff), .tx_pcm_stream(tx_pcm_stream),
      .tx_sig_ff(tx_sig_ff));
   tx_channel_ctrl_host u_tx_channel_ctrl_host (.sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   // 10 MHz clock.
   initial
   begin
      forever #50 sys_clk = ~sys_clk;
   end

   // Compare tasks, one per kind of result.
   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmp_pcm(input logic [7:0] got, input logic [7:0] exp);
      cmp_word({24'h0, got}, {24'h0, exp});
   endtask

   // Test pattern for control and idle bytes; every mode appears across slots.
   function automatic logic [7:0] ctrl_of(input int s);
      return {s[2:0], s[3], s[3:0] ^ 4'h9};
   endfunction
   function automatic logic [7:0] idle_of(input int s);
      return 8'hC3 ^ s[7:0];
   endfunction

   // Expected byte after manipulation; row is the milliwatt phase of the frame.
   function automatic logic [7:0] exp_pcm(input logic [7:0] c, input logic [7:0] id,
                                          input logic [7:0] p, input int row);
      case (c[7:5])
         3'b000: return p;
         3'b001: return p ^ 8'hAA;
         3'b010: return p ^ 8'h55;
         3'b011: return ~p;
         3'b110: return tx_channel_ctrl_pkg::ALAW_MW[8*(7-row) +: 8];
         3'b111: return tx_channel_ctrl_pkg::ULAW_MW[8*(7-row) +: 8];
         default: return id;
      endcase
   endfunction

   // Reset values, unmapped access and pointer storage of an address that launches nothing.
   task automatic t_regs();
      u_tx_channel_ctrl_host.xfer(1'b0, tx_channel_ctrl_pkg::ADDR_POINTER, 32'h0);
      cmp_word(u_tx_channel_ctrl_host.last_rd, {24'h0, tx_channel_ctrl_pkg::RST_POINTER});
      u_tx_channel_ctrl_host.xfer(1'b0, tx_channel_ctrl_pkg::ADDR_BUFFER, 32'h0);
      cmp_word(u_tx_channel_ctrl_host.last_rd, {24'h0, tx_channel_ctrl_pkg::RST_BUFFER});
      u_tx_channel_ctrl_host.xfer(1'b0, tx_channel_ctrl_pkg::ADDR_STATUS, 32'h0);
      cmp_word(u_tx_channel_ctrl_host.last_rd, 32'h0);
      u_tx_channel_ctrl_host.xfer(1'b0, 12'h100, 32'h0);
      cmp_word({31'h0, u_tx_channel_ctrl_host.last_err}, 32'h1);
      u_tx_channel_ctrl_host.xfer(1'b1, tx_channel_ctrl_pkg::ADDR_POINTER, 32'hE5);
      u_tx_channel_ctrl_host.xfer(1'b0, tx_channel_ctrl_pkg::ADDR_POINTER, 32'h0);
      cmp_word(u_tx_channel_ctrl_host.last_rd, 32'hE5);
   endtask

   // Fill all 64 slot bytes, then read every one back through the buffer.
   task automatic t_mem();
      for (int i = 0; i < 64; i++)
         u_tx_channel_ctrl_host.ind_write(7'h20 + i[6:0], (i < 32) ? ctrl_of(i) : idle_of(i - 32));
      for (int i = 0; i < 64; i++)
      begin
         u_tx_channel_ctrl_host.ind_read(7'h20 + i[6:0]);
         cmp_word(u_tx_channel_ctrl_host.last_rd, {24'h0, (i < 32) ? ctrl_of(i) : idle_of(i - 32)});
      end
   endtask

   // Ten frames: eight walk the milliwatt rows, then one without CAS, one with enable off.
   task automatic t_stream();
      logic [7:0] c, p, e;
      logic [3:0] sg;
      u_tx_channel_ctrl_host.xfer(1'b1, tx_channel_ctrl_pkg::ADDR_CFG, 32'h3);
      for (int f = 0; f < 10; f++)
      begin
         if (f == 9)
            u_tx_channel_ctrl_host.xfer(1'b1, tx_channel_ctrl_pkg::ADDR_CFG, 32'h2);
         for (int s = 0; s < 32; s++)
         begin
            c = ctrl_of(s);
            p = {s[4:0], f[2:0]} ^ 8'h5C;
            @(posedge sys_clk);
            slot_valid <= 1'b1;
            slot_num <= s[4:0];
            backplane_tx_pcm <= p;
            backplane_tx_signaling <= ~s[3:0];
            cas_mode <= (f != 8);
            @(posedge sys_clk);
            slot_valid <= 1'b0;
            e = (f == 9) ? p : exp_pcm(c, idle_of(s), p, f % 8);
            sg = (f < 8 && c[tx_channel_ctrl_pkg::POS_SIG_ORIGIN]) ? c[3:0] : ~s[3:0];
            for (int n = 0; n < 6 && tx_valid_ff !== 1'b1; n++)
               @(posedge sys_clk);
            cmp_word({31'h0, tx_valid_ff}, 32'h1);
            cmp_pcm(tx_pcm_stream, e);
            cmp_pcm({4'h0, tx_sig_ff}, {4'h0, sg});
         end
      end
   endtask

   // Report counts and the verdict, then stop.
   task automatic summarize();
      $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Main sequence after 20 cycles of reset.
   initial
   begin
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_regs();
      t_mem();
      t_stream();
      summarize();
   end

   // Watchdog; the run needs about 2500 cycles.
   initial
   begin
      #2000000;
      bad_count++;
      summarize();
   end
endmodule
